// >>> inc/squib_spi_pkg.sv
// Behaviour
// - Sample input on rising, shift on falling
// - Latch byte at select rise, load reply
// - Bank one enable gates drivers 1A 1B
// - Bank two enable gates drivers 2A 2B
// - Reset disables functions, clears shift registers
// - Single eight bit register, MSB first
// - Reply carries previous command's results
// - No-op or undefined command clears diagnostics
// - Functions act at select rise only, except that a bank enable going low drops its drivers at any time
// - Integrity command returns echo byte
// - Unused reply bits read zero
// - Only exact eight bit frames accepted
// - Second programming byte is no-op while firing, except the all-off byte
// - Programming bytes must be back to back
// - Clock level at select fall picks mode
// - Output released while select is high
// - Identification reply bit seven is variant
// - Continuity command latches per channel result
// - Continuity results clear after being sent
package squib_spi_pkg;
    localparam int unsigned FRAME_BITS = 8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;
    localparam logic [3:0] BIT_CNT_OVER = 4'h9;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_ECHO = 8'h96;
    localparam logic [7:0] ECHO_REPLY = 8'h69;
    localparam logic [7:0] CMD_IDENT = 8'hC8;
    localparam logic [7:0] CMD_CONT_FORCE = 8'hC1;
    localparam logic [7:0] CMD_CONT_SENSE = 8'hC2;
    localparam logic [7:0] CMD_ARM_BANK1 = 8'hA0;
    localparam logic [7:0] CMD_ARM_BANK2 = 8'hA1;
    localparam logic [7:0] CMD_ARM_ALL = 8'hA2;
    localparam logic [3:0] CMD_FIRE_HI = 4'h5;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int unsigned CHANNELS = 4;
    // Arbitrary: 0 marks the four-channel part
    localparam logic VARIANT_BIT = 1'b0;
endpackage

// >>> hw/sync2.sv
module sync2 (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Data
    input wire logic d_in,
    output logic q_out
);
    logic meta_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

// >>> hw/squib_driver_spi_command_interface.sv
module squib_driver_spi_command_interface (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Serial link pins
    input wire logic spi_sclk_in,
    input wire logic spi_csn_in,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_out,
    // Bank enables
    input wire logic bank1_fire_enable_in,
    input wire logic bank2_fire_enable_in,
    // Analog diagnostic results
    input wire logic [squib_spi_pkg::CHANNELS-1:0] continuity_ok_in,
    // Driver and diagnostic controls
    output logic [squib_spi_pkg::CHANNELS-1:0] high_side_on_out,
    output logic [squib_spi_pkg::CHANNELS-1:0] low_side_on_out,
    output logic continuity_force_out,
    output logic continuity_sense_out,
    output logic alternate_serial_mode_out,
    output logic [7:0] last_command_out
);
    import squib_spi_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sclk_s, csn_s, mosi_s, en1_s, en2_s;
    logic [CHANNELS-1:0] cont_s;

    sync2 u_sclk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .d_in(spi_sclk_in),
        .q_out(sclk_s));
    // Select is synchronised as active high so its reset value means deselected;
    // otherwise the first edges after reset would look like a false frame
    logic sel_s;
    sync2 u_csn (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .d_in(!spi_csn_in),
        .q_out(sel_s));
    assign csn_s = !sel_s;
    sync2 u_mosi (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .d_in(serial_in_pin_in),
        .q_out(mosi_s));
    sync2 u_en1 (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .d_in(bank1_fire_enable_in),
        .q_out(en1_s));
    sync2 u_en2 (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .d_in(bank2_fire_enable_in),
        .q_out(en2_s));

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_cont
            sync2 u_cont (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
                .d_in(continuity_ok_in[g]), .q_out(cont_s[g]));
        end
    endgenerate

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    // Chip select idles high, so its history resets high to avoid a false edge
    logic sclk_d_r, csn_d_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_d_r <= 1'b0;
            csn_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            csn_d_r <= csn_s;
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cs_rise, selected;
    assign sclk_rise = sclk_s && !sclk_d_r;
    assign sclk_fall = !sclk_s && sclk_d_r;
    assign cs_fall = !csn_s && csn_d_r;
    assign cs_rise = csn_s && !csn_d_r;
    assign selected = !csn_s;

    // ----------------------------------------
    // Shift register and bit count
    // ----------------------------------------
    logic [7:0] shift_r;
    logic [7:0] reply_r;
    logic [3:0] bit_cnt_r;
    logic out_bit_r;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_r <= ZERO_BYTE;
            bit_cnt_r <= BIT_CNT_ZERO;
        end else if (cs_fall) begin
            shift_r <= reply_r;
            bit_cnt_r <= BIT_CNT_ZERO;
        end else if (selected && sclk_rise) begin
            shift_r <= {shift_r[FRAME_BITS-2:0], mosi_s};
            if (bit_cnt_r != BIT_CNT_OVER) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end

    // Output bit changes on falling clock; first bit presented at select fall
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            out_bit_r <= 1'b0;
        end else if (cs_fall) begin
            out_bit_r <= reply_r[FRAME_BITS-1];
        end else if (selected && sclk_fall) begin
            out_bit_r <= shift_r[FRAME_BITS-1];
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            serial_out_pin_out <= 1'b0;
            serial_out_pin_oe_out <= 1'b0;
        end else begin
            serial_out_pin_out <= out_bit_r;
            serial_out_pin_oe_out <= selected && !cs_rise;
        end
    end

    // ----------------------------------------
    // Mode strap at select fall
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            alternate_serial_mode_out <= 1'b0;
        end else if (cs_fall) begin
            alternate_serial_mode_out <= sclk_s;
        end
    end

    // ----------------------------------------
    // Command decode at select rise
    // ----------------------------------------
    logic frame_ok;
    logic [7:0] cmd;
    logic is_arm, is_fire, firing;
    assign frame_ok = cs_rise && (bit_cnt_r == BIT_CNT_FULL);
    assign cmd = shift_r;
    assign is_arm = (cmd == CMD_ARM_BANK1) || (cmd == CMD_ARM_BANK2) || (cmd == CMD_ARM_ALL);
    assign is_fire = (cmd[7:4] == CMD_FIRE_HI);
    assign firing = |high_side_on_out || |low_side_on_out;

    logic arm1_r, arm2_r;
    logic [7:0] reply_nxt;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            last_command_out <= CMD_NOP;
        end else if (frame_ok) begin
            last_command_out <= cmd;
        end
    end

    // Arm state lasts until the next valid frame; any other command between breaks pairing
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            arm1_r <= 1'b0;
            arm2_r <= 1'b0;
        end else if (frame_ok) begin
            arm1_r <= (cmd == CMD_ARM_BANK1) || (cmd == CMD_ARM_ALL);
            arm2_r <= (cmd == CMD_ARM_BANK2) || (cmd == CMD_ARM_ALL);
        end
    end

    // Fire byte layout: bits 0..3 select A/B low and high side of banks
    logic [CHANNELS-1:0] lo_sel, hi_sel;
    assign lo_sel = {cmd[2], cmd[0], cmd[2], cmd[0]};
    assign hi_sel = {cmd[3], cmd[1], cmd[3], cmd[1]};

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            high_side_on_out <= '0;
            low_side_on_out <= '0;
        end else begin
            if (!en1_s) begin
                high_side_on_out[1:0] <= 2'h0;
                low_side_on_out[1:0] <= 2'h0;
            end
            if (!en2_s) begin
                high_side_on_out[3:2] <= 2'h0;
                low_side_on_out[3:2] <= 2'h0;
            end
            if (frame_ok && is_fire && !firing) begin
                if (arm1_r && en1_s) begin
                    high_side_on_out[1:0] <= hi_sel[1:0];
                    low_side_on_out[1:0] <= lo_sel[1:0];
                end
                if (arm2_r && en2_s) begin
                    high_side_on_out[3:2] <= hi_sel[3:2];
                    low_side_on_out[3:2] <= lo_sel[3:2];
                end
            end else if (frame_ok && is_fire && cmd == {CMD_FIRE_HI, 4'h0}) begin
                // Off command always honoured so a stuck driver can be released
                high_side_on_out <= '0;
                low_side_on_out <= '0;
            end
        end
    end

    // Diagnostic mode flags, cleared by any other valid command
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            continuity_force_out <= 1'b0;
            continuity_sense_out <= 1'b0;
        end else if (frame_ok) begin
            continuity_force_out <= (cmd == CMD_CONT_FORCE);
            continuity_sense_out <= (cmd == CMD_CONT_SENSE);
        end
    end

    // Reply selection for the next frame
    always_comb begin
        reply_nxt = ZERO_BYTE;
        if (cmd == CMD_ECHO) begin
            reply_nxt = ECHO_REPLY;
        end else if (cmd == CMD_IDENT) begin
            reply_nxt = {VARIANT_BIT, 7'h00};
        end else if (cmd == CMD_CONT_SENSE) begin
            reply_nxt = {4'h0, cont_s};
        end else if (is_arm || is_fire) begin
            reply_nxt = cmd;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reply_r <= ZERO_BYTE;
        end else if (frame_ok) begin
            // The reply register is the continuity latch; the next select rise reloads it on a valid frame and clears it otherwise
            reply_r <= reply_nxt;
        end else if (cs_rise) begin
            reply_r <= ZERO_BYTE;
        end
    end
endmodule

// >>> tb/squib_spi_sva.sv
module squib_spi_sva (
    // Watched ports
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic spi_csn_in,
    input wire logic bank1_fire_enable_in,
    input wire logic bank2_fire_enable_in,
    input wire logic serial_out_pin_oe_out,
    input wire logic [squib_spi_pkg::CHANNELS-1:0] high_side_on_out,
    input wire logic [squib_spi_pkg::CHANNELS-1:0] low_side_on_out,
    input wire logic continuity_force_out,
    input wire logic continuity_sense_out,
    input wire logic alternate_serial_mode_out,
    input wire logic [7:0] last_command_out
);
    import squib_spi_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    oe_release_a: assert property (spi_csn_in [*6] |-> !serial_out_pin_oe_out)
        else $error("output driven while deselected");
    bank1_gate_a: assert property (!bank1_fire_enable_in [*8] |->
        (high_side_on_out[1:0] | low_side_on_out[1:0]) == 2'h0) else $error("bank one on");
    bank2_gate_a: assert property (!bank2_fire_enable_in [*8] |->
        (high_side_on_out[3:2] | low_side_on_out[3:2]) == 2'h0) else $error("bank two on");
    cmd_at_rise_a: assert property (!$stable(last_command_out) |-> spi_csn_in)
        else $error("command taken while selected");
    mode_at_fall_a: assert property (!$stable(alternate_serial_mode_out) |-> !spi_csn_in)
        else $error("mode changed outside select");
    force_cause_a: assert property ($rose(continuity_force_out) |->
        ##[0:2] last_command_out == CMD_CONT_FORCE) else $error("force without command");
    sense_cause_a: assert property ($rose(continuity_sense_out) |->
        ##[0:2] last_command_out == CMD_CONT_SENSE) else $error("sense without command");
    fire_cause_a: assert property ($rose(|low_side_on_out) |->
        ##[0:2] last_command_out[7:4] == CMD_FIRE_HI) else $error("driver on without fire");
endmodule
bind squib_driver_spi_command_interface squib_spi_sva i_squib_spi_sva (.clk_sys_in,
    .resetn_in, .spi_csn_in, .bank1_fire_enable_in, .bank2_fire_enable_in,
    .serial_out_pin_oe_out, .high_side_on_out, .low_side_on_out, .continuity_force_out,
    .continuity_sense_out, .alternate_serial_mode_out, .last_command_out);

// >>> tb/spi_master_model.sv
module spi_master_model (
    // Link pins
    output logic sclk_out,
    output logic csn_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_out = 1'b0;
        csn_out = 1'b1;
        mosi_out = 1'b1;
    end
    // Clock stands still between frames; a reply bit sampled while the output is released reads as X
    task automatic xfer(input logic [8:0] tx, input int n, input logic idle,
            output logic [7:0] rx);
        rx = 8'h00;
        sclk_out = idle;
        #80 csn_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #80 sclk_out = 1'b0;
            mosi_out = tx[i];
            #80 sclk_out = 1'b1;
            if (i < 8) rx[i] = miso_oe_in ? miso_in : 1'bx;
        end
        #80 sclk_out = idle;
        #80 csn_out = 1'b1;
        mosi_out = ~mosi_out;
        #2500;
    endtask
endmodule

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import squib_spi_pkg::*;
    logic clk_sys_in, resetn_in, sclk, csn, mosi, miso, miso_oe, en1, en2, alt, frc, sns;
    logic [3:0] cont_ok, hs, ls;
    logic [7:0] last_cmd, rx;
    int bad_count, check_count, cycles;
    squib_driver_spi_command_interface i_squib_driver_spi_command_interface (.clk_sys_in,
        .resetn_in, .spi_sclk_in(sclk), .spi_csn_in(csn), .serial_in_pin_in(mosi),
        .serial_out_pin_out(miso), .serial_out_pin_oe_out(miso_oe), .bank1_fire_enable_in(en1),
        .bank2_fire_enable_in(en2), .continuity_ok_in(cont_ok), .high_side_on_out(hs),
        .low_side_on_out(ls), .continuity_force_out(frc), .continuity_sense_out(sns),
        .alternate_serial_mode_out(alt), .last_command_out(last_cmd));
    spi_master_model i_spi_master_model (.sclk_out(sclk), .csn_out(csn), .mosi_out(mosi),
        .miso_in(miso), .miso_oe_in(miso_oe));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [8:0] tx, input int n = 8, input logic idle = 1'b0);
        @(posedge clk_sys_in);
        #1;
        i_spi_master_model.xfer(tx, n, idle, rx);
    endtask
    task automatic set_in(input logic e1, input logic e2, input logic [3:0] c);
        @(posedge clk_sys_in);
        #1;
        en1 = e1;
        en2 = e2;
        cont_ok = c;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_first();
        send(CMD_ECHO);
        check("first reply", rx, ZERO_BYTE);
        send(CMD_IDENT);
        check("echo reply", rx, ECHO_REPLY);
        send(CMD_NOP);
        check("ident reply", rx, {VARIANT_BIT, 7'h00});
    endtask
    task automatic t_cont();
        set_in(1'b0, 1'b0, 4'hA);
        send(CMD_CONT_FORCE);
        check("force on", frc, 8'h01);
        send(CMD_CONT_SENSE);
        check("force cleared", frc, 8'h00);
        check("sense on", sns, 8'h01);
        send(8'hFF);
        check("cont reply", rx, 8'h0A);
        check("sense cleared", sns, 8'h00);
        send(CMD_NOP);
        check("cont latch clear", rx, ZERO_BYTE);
        send(8'hE0);
        send(8'hE8);
        check("harness reply", rx, ZERO_BYTE);
    endtask
    task automatic t_frame();
        for (int n = 7; n <= 9; n += 2) begin
            send(CMD_ECHO);
            send(9'h1C8, n);
            check("short long frame", last_cmd, CMD_ECHO);
            send(CMD_NOP);
            check("reply after bad frame", rx, ZERO_BYTE);
        end
    endtask
    task automatic t_fire();
        set_in(1'b1, 1'b0, 4'h0);
        send(CMD_ARM_BANK1);
        send(8'h53);
        check("fire low", ls, 8'h01);
        check("fire high", hs, 8'h01);
        send(CMD_ARM_BANK1);
        send(8'h5C);
        check("arm echo", rx, CMD_ARM_BANK1);
        check("fire while firing", ls, 8'h01);
        set_in(1'b0, 1'b0, 4'h0);
        repeat (20) @(posedge clk_sys_in);
        check("bank drop", ls, 8'h00);
        send(8'h50);
        set_in(1'b1, 1'b1, 4'h0);
        send(CMD_ARM_ALL);
        send(CMD_ECHO);
        send(8'h53);
        check("split program", ls, 8'h00);
        set_in(1'b1, 1'b0, 4'h0);
        send(CMD_ARM_BANK2);
        send(8'h5C);
        check("bank two gated", hs, 8'h00);
        set_in(1'b1, 1'b1, 4'h0);
        send(CMD_ARM_BANK2);
        send(8'h5C);
        check("bank two high", hs, 8'h08);
        send(8'h50);
        check("all off", ls | hs, 8'h00);
    endtask
    task automatic t_alt();
        send(CMD_ECHO, 8, 1'b1);
        check("alt mode", alt, 8'h01);
        check("alt command", last_cmd, CMD_ECHO);
        send(CMD_NOP);
        check("std mode", alt, 8'h00);
        check("alt echo", rx, ECHO_REPLY);
    endtask
    task automatic t_reset();
        send(CMD_ECHO);
        @(posedge clk_sys_in);
        #1 resetn_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        check("reset clears", last_cmd, 8'h00);
        #1 resetn_in = 1'b1;
        repeat (5) @(posedge clk_sys_in);
        send(CMD_NOP);
        check("reset reply", rx, ZERO_BYTE);
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Ceiling well above the roughly 13000 cycles the scenarios need
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        resetn_in = 1'b0;
        en1 = 1'b0;
        en2 = 1'b0;
        cont_ok = 4'h0;
        repeat (5) @(posedge clk_sys_in);
        #1 resetn_in = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        t_first();
        t_cont();
        t_frame();
        t_fire();
        t_alt();
        t_reset();
        wrap_up();
    end
endmodule
